// ===== verilog/bstp_pkg.sv
package bstp_pkg;

	// controller states, one per node of the standard state diagram
	typedef enum logic [3:0] {
		ST_RESET,
		ST_IDLE,
		ST_SEL_DR,
		ST_CAP_DR,
		ST_SHIFT_DR,
		ST_EXIT1_DR,
		ST_PAUSE_DR,
		ST_EXIT2_DR,
		ST_UPD_DR,
		ST_SEL_IR,
		ST_CAP_IR,
		ST_SHIFT_IR,
		ST_EXIT1_IR,
		ST_PAUSE_IR,
		ST_EXIT2_IR,
		ST_UPD_IR
	} bstp_state_t;

	// instruction register width and capture pattern
	localparam int BSTP_IR_W = 3;
	localparam logic [2:0] BSTP_IR_CAPTURE = 3'h1;

	// instruction codes; all zeros is the external test
	localparam logic [2:0] BSTP_INS_EXTEST = 3'h0;
	localparam logic [2:0] BSTP_INS_IDCODE = 3'h1;
	localparam logic [2:0] BSTP_INS_SAMPLE = 3'h4;
	localparam logic [2:0] BSTP_INS_BYPASS = 3'h7;

	// identification register width and default contents
	localparam int BSTP_ID_W = 32;
	// arbitrary neutral value; bit 0 set as the standard demands
	localparam logic [31:0] BSTP_ID_VALUE = 32'h0000_0001;

	// pin synchroniser: tck, tms, tdi; idle level is high
	localparam int BSTP_PIN_W = 3;
	localparam logic [2:0] BSTP_PIN_RST = 3'h7;
	localparam int BSTP_PIN_TCK = 2;
	localparam int BSTP_PIN_TMS = 1;
	localparam int BSTP_PIN_TDI = 0;

	// reset value of the serial output pair
	localparam logic BSTP_TDO_RST = 1'h0;
	localparam logic BSTP_BYP_CAPTURE = 1'h0;

endpackage

// ===== verilog/bstp_sync.sv
`timescale 1ns/1ps

// three-stage pin synchroniser with agreement filter
module bstp_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] pin_o
);

	logic [WIDTH-1:0] s1; // first stage, read only by s2
	logic [WIDTH-1:0] s2; // second stage
	logic [WIDTH-1:0] s3; // third stage
	logic [WIDTH-1:0] filt; // accepted level
	logic [WIDTH-1:0] next_filt;

	// a bit changes only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
		end
	endgenerate

	// register stages; frozen while clock enable is low
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			filt <= RST_VAL;
		end else if (ce_i) begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
		end
	end

	assign pin_o = filt;

endmodule

// ===== verilog/bstp_shreg.sv
`timescale 1ns/1ps

// capture-and-shift register, shifts toward bit 0
module bstp_shreg #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cap_i,
	input wire logic shift_i,
	input wire logic [WIDTH-1:0] cap_val_i,
	input wire logic sin_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] q; // register contents
	logic [WIDTH-1:0] next_q;

	// capture wins over shift; they never coincide anyway
	generate
		if (WIDTH > 1) begin : g_wide
			// new bit enters at the top
			always_comb begin
				next_q = q;
				if (cap_i) begin
					next_q = cap_val_i;
				end else if (shift_i) begin
					next_q = {sin_i, q[WIDTH-1:1]};
				end
			end
		end else begin : g_one
			// single stage takes the input directly
			always_comb begin
				next_q = q;
				if (cap_i) begin
					next_q = cap_val_i;
				end else if (shift_i) begin
					next_q[0] = sin_i;
				end
			end
		end
	endgenerate

	// register only
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= RST_VAL;
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	assign q_o = q;

endmodule

// ===== verilog/bstp_tap.sv
`timescale 1ns/1ps

// Behaviour
// RL1: stays reset and idle until test clock toggles
// RL2: inputs on tck rise, outputs on fall
// RL3: tms alone steers the standard state machine
// RL4: undriven tms reads as one
// RL5: undriven tdi shifts in a one
// RL6: scan path chosen by state and instruction
// RL7: tdo enabled in shift states, falling edge
// RL8: five tms-high rising edges reach reset state
// RL9: only power-up and tms reset the controller
// RL10: controller resets itself at power-up
// RL11: unused board leaves pins floating, tdo open
// RL12: 3-bit instruction, preset to identify instruction
// RL13: capture-ir loads 01 into the low bits
// RL14: bypass is one flip-flop, one clock delay
// RL15: 32-bit identity captured, bit 0 first out
// RL16: tdo high-impedance outside the shift states
module bstp_tap
	import bstp_pkg::*;
#(
	parameter logic [BSTP_ID_W-1:0] ID_VALUE = BSTP_ID_VALUE
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tms_drv_i,
	input wire logic tdi_i,
	input wire logic tdi_drv_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic tap_reset_o,
	output logic [BSTP_IR_W-1:0] instr_o
);

	// next-state decode of the standard diagram
	function automatic bstp_state_t tap_next(input bstp_state_t s,
		input logic m);
		unique case (s)
			// reset and idle
			ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
			ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
			// data register column
			ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			// instruction register column
			ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
		endcase
	endfunction

	// true when the instruction routes the identity register
	function automatic logic sel_id(input logic [BSTP_IR_W-1:0] ins);
		sel_id = (ins == BSTP_INS_IDCODE);
	endfunction

	// pin conditioning: pull-up merge, synchroniser and the
	// edge pulses of the filtered test clock

	logic [BSTP_PIN_W-1:0] pin_raw; // pins after pull-up merge
	logic [BSTP_PIN_W-1:0] pin_s; // synchronised, filtered pins
	logic tck_s; // synchronised test clock
	logic tms_s; // synchronised mode select
	logic tdi_s; // synchronised serial input
	logic tck_q; // test clock one cycle ago
	logic next_tck_q;
	logic tck_rise; // one-cycle pulse on rising edge
	logic tck_fall; // one-cycle pulse on falling edge

	// a pin nobody drives is pulled high by the pad
	always_comb begin
		// an unused test clock is held high by its pull-up
		pin_raw[BSTP_PIN_TCK] = tck_i;
		pin_raw[BSTP_PIN_TMS] = tms_i | ~tms_drv_i; // see RL4
		pin_raw[BSTP_PIN_TDI] = tdi_i | ~tdi_drv_i; // see RL5
	end

	// four flops per pin, idle high so no false edge at start
	bstp_sync #(
		.WIDTH(BSTP_PIN_W),
		.RST_VAL(BSTP_PIN_RST)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(pin_raw),
		.pin_o(pin_s)
	);

	assign tck_s = pin_s[BSTP_PIN_TCK];
	assign tms_s = pin_s[BSTP_PIN_TMS];
	assign tdi_s = pin_s[BSTP_PIN_TDI];

	// edge detection of the filtered test clock
	// a phase shorter than two system cycles may vanish
	always_comb begin
		next_tck_q = tck_s;
		// each pulse lasts exactly one system cycle
		tck_rise = tck_s & ~tck_q;
		tck_fall = ~tck_s & tck_q;
	end

	// clock history register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			// idle high like the synchroniser, so no false edge
			tck_q <= BSTP_PIN_RST[BSTP_PIN_TCK];
		end else if (ce_i) begin
			// frozen while clock enable is low
			tck_q <= next_tck_q;
		end
	end

	// controller state machine, clocked by the test-clock rise
	// and steered by the filtered mode select

	bstp_state_t state; // current controller state
	bstp_state_t next_state;

	// moves only on a rising test-clock edge, steered by tms
	always_comb begin
		next_state = state;
		// mode select is taken at the accepted rise only
		if (tck_rise) begin
			next_state = tap_next(state, tms_s); // see RL2 see RL3 see RL8
		end
	end

	// power-up reset is the only other way into reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= ST_RESET; // see RL1 see RL9 see RL10
		end else if (ce_i) begin
			// follow the decoded next state
			state <= next_state;
		end
	end

	// instruction path: shift stage in front, active
	// instruction behind it

	logic [BSTP_IR_W-1:0] ir_q; // instruction shift stage
	logic [BSTP_IR_W-1:0] instr; // active instruction
	logic [BSTP_IR_W-1:0] next_instr;
	logic ir_cap; // capture pulse
	logic ir_shift; // shift pulse

	assign ir_cap = tck_rise & (state == ST_CAP_IR);
	assign ir_shift = tck_rise & (state == ST_SHIFT_IR);

	// shift stage loads 01 in the low bits on capture
	// its reset value is the same capture pattern
	bstp_shreg #(
		.WIDTH(BSTP_IR_W),
		.RST_VAL(BSTP_IR_CAPTURE)
	) u_ir (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cap_i(ir_cap), // see RL13
		.shift_i(ir_shift),
		.cap_val_i(BSTP_IR_CAPTURE),
		.sin_i(tdi_s),
		.q_o(ir_q)
	);

	// shifted instruction takes effect in update-ir only
	// the shift stage holds a half-loaded word while shifting,
	// so the active word must never follow it directly
	always_comb begin
		next_instr = instr;
		if (state == ST_RESET) begin
			// reset state presets, one cycle late
			next_instr = BSTP_INS_IDCODE; // see RL12
		end else if (tck_rise && state == ST_UPD_IR) begin
			// update-ir loads the shifted word
			next_instr = ir_q;
		end
	end

	// active instruction register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			instr <= BSTP_INS_IDCODE; // see RL12
		end else if (ce_i) begin
			// frozen while clock enable is low
			instr <= next_instr;
		end
	end

	// data registers: identity and bypass, chosen by the
	// active instruction

	logic [BSTP_ID_W-1:0] id_q; // identity shift register
	logic id_cap; // capture pulse for identity
	logic id_shift; // shift pulse for identity
	logic byp; // bypass flip-flop
	logic next_byp;

	// path choice follows state and instruction
	assign id_cap = tck_rise & (state == ST_CAP_DR) & sel_id(instr);
	assign id_shift = tck_rise & (state == ST_SHIFT_DR) & sel_id(instr);

	// identity register, bit 0 leaves first
	// reset and capture values are the same word
	bstp_shreg #(
		.WIDTH(BSTP_ID_W),
		.RST_VAL(ID_VALUE)
	) u_id (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cap_i(id_cap), // see RL15
		.shift_i(id_shift), // see RL6
		.cap_val_i(ID_VALUE),
		.sin_i(tdi_s),
		.q_o(id_q)
	);

	// bypass: every other instruction, one bit of delay
	// no boundary cells in this block, so all other codes land here
	always_comb begin
		next_byp = byp;
		if (tck_rise && !sel_id(instr)) begin
			// capture loads a known zero
			if (state == ST_CAP_DR) begin
				next_byp = BSTP_BYP_CAPTURE;
			end else if (state == ST_SHIFT_DR) begin
				// one stage between tdi and tdo
				next_byp = tdi_s; // see RL14 see RL6
			end
		end
	end

	// bypass register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			byp <= BSTP_BYP_CAPTURE;
		end else if (ce_i) begin
			// frozen while clock enable is low
			byp <= next_byp;
		end
	end

	// serial output: data and enable, both moved by the
	// accepted fall of the test clock

	logic tdo; // registered serial data
	logic tdo_oe; // registered output enable
	logic next_tdo;
	logic next_tdo_oe;

	// output and enable change on the falling edge only
	always_comb begin
		next_tdo = tdo;
		next_tdo_oe = tdo_oe;
		// both hold their values between falls
		if (tck_fall) begin
			// enabled in the two shift states, released elsewhere
			next_tdo_oe = (state == ST_SHIFT_IR) ||
				(state == ST_SHIFT_DR); // see RL7 see RL16
			if (state == ST_SHIFT_IR) begin
				// instruction stage, low bit first
				next_tdo = ir_q[0];
			end else if (state == ST_SHIFT_DR) begin
				// routed data register, low bit first
				next_tdo = sel_id(instr) ? id_q[0] : byp; // see RL6
			end
		end
	end

	// output register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			// released and low
			tdo <= BSTP_TDO_RST;
			tdo_oe <= 1'b0;
		end else if (ce_i) begin
			// one cycle after the accepted fall
			tdo <= next_tdo; // see RL2
			tdo_oe <= next_tdo_oe;
		end
	end

	// tdo keeps its value while released; the pad floats it
	// status for the memory core: hold functional mode in reset
	assign tdo_o = tdo;
	assign tdo_oe_o = tdo_oe;
	assign tap_reset_o = (state == ST_RESET);
	assign instr_o = instr;

endmodule

// ===== dv/bstp_tap_props.sv
`timescale 1ns/1ps

// pin-level watcher of the test port
module bstp_tap_props
	import bstp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tms_drv_i,
	input wire logic tdi_i,
	input wire logic tdi_drv_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire logic tap_reset_o,
	input wire logic [BSTP_IR_W-1:0] instr_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i || !ce_i);
	logic tck_q, next_tck_q; // pin one cycle back
	logic last_tms, next_last_tms; // mode at the last rise
	logic [2:0] n_hi, next_n_hi; // high-mode rises in a row
	logic [3:0] lo_age, next_lo_age; // cycles since low-mode rise
	wire rise = tck_i & ~tck_q;
	wire tms_eff = tms_i | ~tms_drv_i; // floating reads high

	// rise bookkeeping
	always_comb begin
		next_tck_q = tck_i;
		next_last_tms = last_tms;
		next_n_hi = n_hi;
		next_lo_age = lo_age + {3'h0, lo_age != 4'hf};
		if (rise) begin
			next_last_tms = tms_eff;
			next_n_hi = tms_eff ? n_hi + {2'h0, n_hi != 3'h5} : 3'h0;
			if (!tms_eff)
				next_lo_age = 4'h0;
		end
	end

	// register only; reset means already in reset state
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tck_q <= 1'h1;
			last_tms <= 1'h1;
			n_hi <= 3'h5;
			lo_age <= 4'hf;
		end else begin
			tck_q <= next_tck_q;
			last_tms <= next_last_tms;
			n_hi <= next_n_hi;
			lo_age <= next_lo_age;
		end
	end

	sequence s_reach_reset;
		##[0:8] tap_reset_o;
	endsequence

	AST_RST_VAL: assert property (disable iff (1'b0)
		$fell(rst_i) |-> tap_reset_o && !tdo_oe_o
		&& instr_o == BSTP_INS_IDCODE) else $error("bad reset values");
	AST_IR_PRESET: assert property (
		tap_reset_o |-> ##2 instr_o == BSTP_INS_IDCODE)
		else $error("ir not preset");
	AST_OE_EDGE: assert property (
		$changed(tdo_oe_o) && !$past(rst_i) |-> !$past(tck_i, 3))
		else $error("enable moved off falling edge");
	AST_TDO_EDGE: assert property (
		$changed(tdo_o) && !$past(rst_i) |-> !$past(tck_i, 3))
		else $error("tdo moved off falling edge");
	AST_FIVE_HI: assert property (
		n_hi == 3'h5 && $past(n_hi) != 3'h5 |-> s_reach_reset)
		else $error("five high rises missed reset");
	AST_LEAVE_RST: assert property (
		$fell(tap_reset_o) |-> lo_age <= 4'h8)
		else $error("left reset without low mode");
	AST_ENTER_RST: assert property (
		$rose(tap_reset_o) && !$past(rst_i) |-> n_hi >= 3'h3)
		else $error("reset entered without high mode");
	AST_OE_ON: assert property (
		$rose(tdo_oe_o) |-> !$past(last_tms, 3))
		else $error("enable rose without low mode");
	AST_OE_OFF: assert property (
		$fell(tdo_oe_o) && !$past(rst_i) |-> $past(last_tms, 3))
		else $error("enable fell without high mode");
	AST_OE_RST: assert property (
		tap_reset_o |-> !tdo_oe_o) else $error("tdo driven in reset");
endmodule

bind bstp_tap bstp_tap_props u_props (.clk_sys_i(clk_sys_i),
	.rst_i(rst_i), .ce_i(ce_i), .tck_i(tck_i), .tms_i(tms_i),
	.tms_drv_i(tms_drv_i), .tdi_i(tdi_i), .tdi_drv_i(tdi_drv_i),
	.tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .tap_reset_o(tap_reset_o),
	.instr_o(instr_o));

// ===== dv/bstp_ctl_model.sv
`timescale 1ns/1ps

// scan controller; tck stands high between frames
module bstp_ctl_model (
	input wire logic clk_sys_i,
	input wire logic tdo_i,
	input wire logic tdo_oe_i,
	output logic tck_o,
	output logic tms_o,
	output logic tms_drv_o,
	output logic tdi_o,
	output logic tdi_drv_o
);
	logic so; // tdo seen late in the high phase
	logic oe; // enable seen with it

	// idle pins
	initial begin
		tck_o = 1'h1;
		tms_o = 1'h1;
		tms_drv_o = 1'h1;
		tdi_o = 1'h1;
		tdi_drv_o = 1'h1;
	end

	// one tck period: 5 clk low, 5 clk high
	task tick(input logic ms, input logic md, input logic di,
		input logic dd);
		@(negedge clk_sys_i);
		tck_o = 1'h0;
		tms_drv_o = md;
		tms_o = md ? ms : ~tms_o; // released pin shows junk
		tdi_drv_o = dd;
		tdi_o = dd ? di : ~tdi_o;
		repeat (5) @(negedge clk_sys_i);
		tck_o = 1'h1;
		repeat (4) @(negedge clk_sys_i);
		so = tdo_i;
		oe = tdo_oe_i;
	endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps

// bench: power-up, ir loads, id read, bypass, tms reset
module tb_top
	import bstp_pkg::*;
;
	localparam logic [31:0] ID_TB = 32'h5a3c_96e1; // arbitrary value
	logic clk_sys_i = 1'h0;
	logic rst_i = 1'h1;
	logic ce_i = 1'h1;
	logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, tap_reset;
	logic [BSTP_IR_W-1:0] instr;
	logic [31:0] got; // bits gathered by a scan
	logic [2:0] lst [3] = '{BSTP_INS_EXTEST, BSTP_INS_SAMPLE,
		BSTP_INS_BYPASS};
	int miscompares = 0;
	int n_compared = 0;

	bstp_tap #(.ID_VALUE(ID_TB)) u_dut (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .ce_i(ce_i), .tck_i(tck), .tms_i(tms),
		.tms_drv_i(tms_drv), .tdi_i(tdi), .tdi_drv_i(tdi_drv),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .tap_reset_o(tap_reset),
		.instr_o(instr));
	bstp_ctl_model u_ctl (.clk_sys_i(clk_sys_i), .tdo_i(tdo),
		.tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
		.tms_drv_o(tms_drv), .tdi_o(tdi), .tdi_drv_o(tdi_drv));

	// 125 MHz system clock
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// driven mode bits, lsb first
	task automatic walk(input logic [7:0] s, input int n);
		for (int i = 0; i < n; i++)
			u_ctl.tick(s[i], 1'h1, 1'h0, 1'h1);
	endtask

	// shift n bits, leave via exit1, update, idle
	task automatic scan(input int n, input logic [31:0] din,
		input logic [31:0] dd);
		got = '0;
		for (int i = 0; i < n; i++) begin
			u_ctl.tick(i == n - 1, 1'h1, din[i], dd[i]);
			got[i] = u_ctl.so;
			chk(u_ctl.oe, 1'h1);
		end
		walk(8'h01, 1);
		chk(u_ctl.oe, 1'h0);
		walk(8'h00, 1);
	endtask

	// load an instruction from idle
	task automatic load_ir(input logic [2:0] ins);
		walk(8'h03, 4);
		scan(3, {29'h0, ins}, 32'h7);
		chk(got[1:0], 2'h1);
		repeat (2) @(negedge clk_sys_i); // update acts 5 clk late
		chk(instr, ins);
	endtask

	task automatic t_power_up;
		chk(tap_reset, 1'h1);
		chk(instr, BSTP_INS_IDCODE);
		chk(tdo_oe, 1'h0);
		repeat (3) u_ctl.tick(1'h0, 1'h0, 1'h0, 1'h0);
		chk(tap_reset, 1'h1);
		walk(8'h00, 1);
	endtask

	task automatic t_idcode;
		load_ir(BSTP_INS_IDCODE);
		walk(8'h01, 3);
		scan(32, 32'h0, 32'h0);
		chk(got, ID_TB);
	endtask

	// bit 4 floats: shifts a one; first bit is the captured zero
	task automatic t_bypass;
		foreach (lst[k]) begin
			load_ir(lst[k]);
			walk(8'h01, 3);
			scan(8, 32'h2c, 32'hef);
			chk(got, 32'h78);
		end
	endtask

	task automatic t_tms_reset;
		load_ir(BSTP_INS_BYPASS);
		walk(8'h01, 3);
		walk(8'h0f, 4);
		repeat (6) @(negedge clk_sys_i);
		chk(tap_reset, 1'h0);
		walk(8'h01, 1);
		repeat (6) @(negedge clk_sys_i);
		chk(tap_reset, 1'h1);
		chk(instr, BSTP_INS_IDCODE);
		walk(8'h00, 1);
		load_ir(BSTP_INS_SAMPLE);
		rst_i = 1'h1;
		repeat (2) @(negedge clk_sys_i);
		rst_i = 1'h0;
		chk(instr, BSTP_INS_IDCODE);
		chk(tap_reset, 1'h1);
	endtask

	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys_i);
		rst_i = 1'h0;
		repeat (4) @(negedge clk_sys_i);
		t_power_up();
		t_idcode();
		t_bypass();
		t_tms_reset();
		conclude();
	end

	// watchdog: about 25 times the expected run
	initial begin
		#300000;
		miscompares++;
		conclude();
	end
endmodule
